// File: rtl/tsrc_cmd_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "tsrc_map.vh"

// turns a write at the shared command offset into one-cycle pulses;
// nothing is stored, so the bits clear themselves by construction
module tsrc_cmd_decode (
  input  wire       i_wr,
  input  wire [7:0] i_addr,
  input  wire [3:0] i_sfr_page,
  input  wire [7:0] i_wdata,
  output wire [3:0] o_start,
  output wire [3:0] o_reload,
  output wire [3:0] o_stop
);

  wire       hit;
  wire [3:0] cmd_bits;

  // order t0, t1, t2, t2 low; reserved bits are ignored
  assign hit      = i_wr && (i_addr == `TSRC_OFF_CMD);
  assign cmd_bits = {i_wdata[`TSRC_CMD_T2L], i_wdata[`TSRC_CMD_T2],
                     i_wdata[`TSRC_CMD_T1],  i_wdata[`TSRC_CMD_T0]};

  // a zero bit gives no pulse, so it has no effect
  assign o_start  = (hit && i_sfr_page == `TSRC_PAGE_START)
                    ? cmd_bits : 4'h0;
  assign o_reload = (hit && i_sfr_page == `TSRC_PAGE_RELOAD)
                    ? cmd_bits : 4'h0;
  assign o_stop   = (hit && i_sfr_page == `TSRC_PAGE_STOP)
                    ? cmd_bits : 4'h0;

endmodule // tsrc_cmd_decode
`default_nettype wire

// File: rtl/tsrc_map.vh
// Function
// - start bit two sets timer 2 run
// - split-low start bit sets low-byte run
// - start bit one sets timer 1 run
// - start bit zero sets timer 0 run
// - several start bits start together
// - command bits self-clear; zero does nothing
// - timer 2 reload: both bytes, split high
// - split-low reload reloads low byte
// - timer 1 reload in mode 2
// - timer 0 reload in mode 2
// - stop bit two clears timer 2 run
// - split-low stop clears low-byte run
// - stop bit one clears timer 1 run
// - stop bit zero clears timer 0 run
// - pin field routes timer 2 pins
// - capture bytes readable, writable, reset zero
// - count bytes readable, writable, reset zero
// - split bit chooses 16-bit or halves
`ifndef TSRC_MAP_VH
`define TSRC_MAP_VH

// register offsets
`define TSRC_OFF_CMD         8'h95
`define TSRC_OFF_AUX_PIN     8'hA4
`define TSRC_OFF_CAP_LOW     8'hCA
`define TSRC_OFF_CAP_HIGH    8'hCB
`define TSRC_OFF_CNT_LOW     8'hCC
`define TSRC_OFF_CNT_HIGH    8'hCD
`define TSRC_OFF_RUN_CTRL    8'h9A
`define TSRC_OFF_MODE_CTRL   8'h9B

// pages that select which command register sits at the shared offset, and the page of the pin select register
`define TSRC_PAGE_START      4'h1
`define TSRC_PAGE_RELOAD     4'h2
`define TSRC_PAGE_STOP       4'h3
`define TSRC_PAGE_AUX        4'h1

// command bit positions, shared by all three command registers
`define TSRC_CMD_T0          0
`define TSRC_CMD_T1          1
`define TSRC_CMD_T2          2
`define TSRC_CMD_T2L         5

// run control register bits
`define TSRC_RUN_T0          0
`define TSRC_RUN_T1          1
`define TSRC_RUN_T2          2
`define TSRC_RUN_T2L         3

// mode control register bits
`define TSRC_MODE_SPLIT      7
`define TSRC_MODE_CLKOUT     2

// pin route field
`define TSRC_PIN_HI          7
`define TSRC_PIN_LO          6
`define TSRC_AUX_WO_BIT      2

// reset values
`define TSRC_RST_BYTE        8'h00
`define TSRC_RST_AUX         8'h00

`endif

// File: rtl/tsrc_pin_route.v
`timescale 1ns/1ps
`default_nettype none

// steers the timer 2 clock pin and trigger pin to one of four pairs
module tsrc_pin_route (
  input  wire [1:0] i_sel,
  input  wire [3:0] i_clk_pins,
  input  wire [3:0] i_trig_pins,
  input  wire       i_clkout_en,
  output wire       o_clk_in,
  output wire       o_trig_in,
  output wire [3:0] o_pin_oe
);

  // one-hot pair select, reused for the output enables
  wire [3:0] pair;

  assign pair      = 4'h1 << i_sel;
  assign o_clk_in  = |(i_clk_pins & pair);
  assign o_trig_in = |(i_trig_pins & pair);
  assign o_pin_oe  = i_clkout_en ? pair : 4'h0;

endmodule // tsrc_pin_route
`default_nettype wire

// File: rtl/tsrc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "tsrc_map.vh"

module tsrc_top (
  input  wire       i_core_clk,
  input  wire       i_rst_b,
  input  wire [7:0] i_addr,
  input  wire [3:0] i_sfr_page,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_t2_tick,
  input  wire       i_t2l_tick,
  input  wire       i_t0_mode2,
  input  wire       i_t1_mode2,
  input  wire [3:0] i_t2_pin_in,
  input  wire [3:0] i_t2_external_trigger_pin_pin_in,
  output wire [3:0] o_t2_pin_out,
  output wire [3:0] o_t2_pin_oe,
  output reg        o_t2_count_in,
  output reg        o_t2_external_trigger_pin_in,
  output wire       o_t0_run,
  output wire       o_t1_run,
  output wire       o_t2_run,
  output wire       o_t2l_run,
  output reg        o_t0_reload,
  output reg        o_t1_reload,
  output reg        o_t2_overflow,
  output reg        o_t2l_overflow,
  output wire       o_t2_split
);

  // address match used by every storage register write decode
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // byte increment with carry out, used for both count bytes
  function [8:0] inc8;
    input [7:0] val;
    begin
      inc8 = {1'b0, val} + 9'h001;
    end
  endfunction

  // storage
  reg  [7:0] cap_low_reg;
  reg  [7:0] cap_high_reg;
  reg  [7:0] cnt_low_reg;
  reg  [7:0] cnt_high_reg;
  reg  [7:0] aux_pin_reg;
  reg  [3:0] run_reg;
  reg        split_reg;
  reg        clkout_reg;
  reg        clk_tog_reg;

  reg  [7:0] cnt_low_next;
  reg  [7:0] cnt_high_next;
  reg  [3:0] run_next;
  reg  [7:0] rdata_next;
  reg        ovf_next;
  reg        ovfl_next;

  wire [3:0] start_pulse;
  wire [3:0] reload_pulse;
  wire [3:0] stop_pulse;
  wire       clk_in_w;
  wire       trig_in_w;

  wire       wr_cap_low;
  wire       wr_cap_high;
  wire       wr_cnt_low;
  wire       wr_cnt_high;
  wire       wr_aux;
  wire       wr_run;
  wire       wr_mode;
  wire [8:0] low_inc;
  wire [8:0] high_inc;
  wire [8:0] full_low_inc;
  wire       low_count_en;
  wire       high_count_en;

  // command writes become start, reload and stop pulses
  tsrc_cmd_decode u_cmd (
    .i_wr       (i_wr),
    .i_addr     (i_addr),
    .i_sfr_page (i_sfr_page),
    .i_wdata    (i_wdata),
    .o_start    (start_pulse),
    .o_reload   (reload_pulse),
    .o_stop     (stop_pulse)
  );

  // routed pins for the timer 2 clock and trigger
  tsrc_pin_route u_pin (
    .i_sel       (aux_pin_reg[`TSRC_PIN_HI:`TSRC_PIN_LO]),
    .i_clk_pins  (i_t2_pin_in),
    .i_trig_pins (i_t2_external_trigger_pin_pin_in),
    .i_clkout_en (clkout_reg),
    .o_clk_in    (clk_in_w),
    .o_trig_in   (trig_in_w),
    .o_pin_oe    (o_t2_pin_oe)
  );

  // write decodes for the plain storage registers
  assign wr_cap_low  = i_wr && hit(i_addr, `TSRC_OFF_CAP_LOW);
  assign wr_cap_high = i_wr && hit(i_addr, `TSRC_OFF_CAP_HIGH);
  assign wr_cnt_low  = i_wr && hit(i_addr, `TSRC_OFF_CNT_LOW);
  assign wr_cnt_high = i_wr && hit(i_addr, `TSRC_OFF_CNT_HIGH);
  assign wr_aux      = i_wr && hit(i_addr, `TSRC_OFF_AUX_PIN) &&
                       (i_sfr_page == `TSRC_PAGE_AUX);
  assign wr_run      = i_wr && hit(i_addr, `TSRC_OFF_RUN_CTRL);
  assign wr_mode     = i_wr && hit(i_addr, `TSRC_OFF_MODE_CTRL);

  // count enables; the low byte has its own run bit only in split mode
  assign high_count_en = run_reg[`TSRC_RUN_T2] && i_t2_tick;
  assign low_count_en  = split_reg ? (run_reg[`TSRC_RUN_T2L] && i_t2l_tick)
                                   : high_count_en;
  assign low_inc       = inc8(cnt_low_reg);
  assign high_inc      = inc8(cnt_high_reg);
  assign full_low_inc  = low_inc;

  // run control next state; starts act on all selected bits at once (the low-half bit only in split mode),
  // so a single command write starts several timers in one cycle
  always @* begin
    run_next = run_reg;
    if (wr_run) begin
      run_next = i_wdata[3:0];
    end
    if (start_pulse[`TSRC_CMD_T0]) begin
      run_next[`TSRC_RUN_T0] = 1'b1;
    end
    if (start_pulse[`TSRC_CMD_T1]) begin
      run_next[`TSRC_RUN_T1] = 1'b1;
    end
    if (start_pulse[`TSRC_CMD_T2]) begin
      run_next[`TSRC_RUN_T2] = 1'b1;
    end
    if (start_pulse[3] && split_reg) begin
      run_next[`TSRC_RUN_T2L] = 1'b1;
    end
    if (stop_pulse[`TSRC_CMD_T0]) begin
      run_next[`TSRC_RUN_T0] = 1'b0;
    end
    if (stop_pulse[`TSRC_CMD_T1]) begin
      run_next[`TSRC_RUN_T1] = 1'b0;
    end
    if (stop_pulse[`TSRC_CMD_T2]) begin
      run_next[`TSRC_RUN_T2] = 1'b0;
    end
    if (stop_pulse[3] && split_reg) begin
      run_next[`TSRC_RUN_T2L] = 1'b0;
    end
  end

  // timer 2 count next state; a software write to a count byte wins
  // over counting and reload so that software can preset the timer
  always @* begin
    cnt_low_next  = cnt_low_reg;
    cnt_high_next = cnt_high_reg;
    ovf_next      = 1'b0;
    ovfl_next     = 1'b0;
    if (!split_reg) begin
      // one 16-bit timer, auto-reloaded from the capture pair
      if (high_count_en) begin
        cnt_low_next = full_low_inc[7:0];
        if (full_low_inc[8]) begin
          cnt_high_next = high_inc[7:0];
          if (high_inc[8]) begin
            cnt_low_next  = cap_low_reg;
            cnt_high_next = cap_high_reg;
            ovf_next      = 1'b1;
          end
        end
      end
      if (reload_pulse[`TSRC_CMD_T2]) begin
        cnt_low_next  = cap_low_reg;
        cnt_high_next = cap_high_reg;
      end
    end else begin
      // two 8-bit halves, each reloaded from its own capture byte
      if (high_count_en) begin
        cnt_high_next = high_inc[7:0];
        if (high_inc[8]) begin
          cnt_high_next = cap_high_reg;
          ovf_next      = 1'b1;
        end
      end
      if (low_count_en) begin
        cnt_low_next = low_inc[7:0];
        if (low_inc[8]) begin
          cnt_low_next = cap_low_reg;
          ovfl_next    = 1'b1;
        end
      end
      if (reload_pulse[`TSRC_CMD_T2]) begin
        cnt_high_next = cap_high_reg;
      end
      if (reload_pulse[3]) begin
        cnt_low_next = cap_low_reg;
      end
    end
    if (wr_cnt_low) begin
      cnt_low_next = i_wdata;
    end
    if (wr_cnt_high) begin
      cnt_high_next = i_wdata;
    end
  end

  // read mux; command registers hold nothing and read as zero
  always @* begin
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `TSRC_OFF_CMD: begin
          rdata_next = 8'h00;
        end
        `TSRC_OFF_CAP_LOW: begin
          rdata_next = cap_low_reg;
        end
        `TSRC_OFF_CAP_HIGH: begin
          rdata_next = cap_high_reg;
        end
        `TSRC_OFF_CNT_LOW: begin
          rdata_next = cnt_low_reg;
        end
        `TSRC_OFF_CNT_HIGH: begin
          rdata_next = cnt_high_reg;
        end
        `TSRC_OFF_AUX_PIN: begin
          if (i_sfr_page == `TSRC_PAGE_AUX) begin
            rdata_next = aux_pin_reg;
          end
        end
        `TSRC_OFF_RUN_CTRL: begin
          rdata_next = {4'h0, run_reg};
        end
        `TSRC_OFF_MODE_CTRL: begin
          rdata_next = {split_reg, 4'h0, clkout_reg, 2'b00};
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // capture / reload value bytes
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cap_low_reg  <= `TSRC_RST_BYTE;
      cap_high_reg <= `TSRC_RST_BYTE;
    end else begin
      if (wr_cap_low) begin
        cap_low_reg <= i_wdata;
      end
      if (wr_cap_high) begin
        cap_high_reg <= i_wdata;
      end
    end
  end

  // count bytes and overflow pulses
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_low_reg    <= `TSRC_RST_BYTE;
      cnt_high_reg   <= `TSRC_RST_BYTE;
      o_t2_overflow  <= 1'b0;
      o_t2l_overflow <= 1'b0;
    end else begin
      cnt_low_reg    <= cnt_low_next;
      cnt_high_reg   <= cnt_high_next;
      o_t2_overflow  <= ovf_next;
      o_t2l_overflow <= ovfl_next;
    end
  end

  // run controls and mode bits
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_reg    <= 4'h0;
      split_reg  <= 1'b0;
      clkout_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      if (wr_mode) begin
        split_reg  <= i_wdata[`TSRC_MODE_SPLIT];
        clkout_reg <= i_wdata[`TSRC_MODE_CLKOUT];
      end
    end
  end

  // pin select register; the write-only bit is not kept
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aux_pin_reg <= `TSRC_RST_AUX;
    end else if (wr_aux) begin
      aux_pin_reg <= i_wdata & 8'hFB;
    end
  end

  // timer 0 and 1 reloads only mean something in their mode 2; the
  // counters live elsewhere, so a one-cycle pulse is handed out
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_t0_reload <= 1'b0;
      o_t1_reload <= 1'b0;
    end else begin
      o_t0_reload <= reload_pulse[`TSRC_CMD_T0] && i_t0_mode2;
      o_t1_reload <= reload_pulse[`TSRC_CMD_T1] && i_t1_mode2;
    end
  end

  // clock-out toggles on each timer 2 overflow; routed pins registered
  // so downstream edge detection sees clean single-cycle samples
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_tog_reg   <= 1'b0;
      o_t2_count_in <= 1'b0;
      o_t2_external_trigger_pin_in     <= 1'b0;
    end else begin
      if (ovf_next && clkout_reg) begin
        clk_tog_reg <= ~clk_tog_reg;
      end
      o_t2_count_in <= clk_in_w;
      o_t2_external_trigger_pin_in     <= trig_in_w;
    end
  end

  // read data stands only in the cycle after the read strobe
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_next;
    end
  end

  assign o_t2_pin_out = {4{clk_tog_reg}};
  assign o_t0_run     = run_reg[`TSRC_RUN_T0];
  assign o_t1_run     = run_reg[`TSRC_RUN_T1];
  assign o_t2_run     = run_reg[`TSRC_RUN_T2];
  assign o_t2l_run    = run_reg[`TSRC_RUN_T2L];
  assign o_t2_split   = split_reg;

endmodule // tsrc_top
`default_nettype wire

// File: sim/test_tsrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_tsrc_top;
  logic       i_core_clk, i_rst_b, i_wr, i_rd, i_t0_mode2, i_t1_mode2;
  logic       i_t2_tick, i_t2l_tick;
  logic [7:0] i_addr, i_wdata;
  logic [3:0] i_sfr_page, i_t2_pin_in, i_t2_external_trigger_pin_pin_in;
  wire  [7:0] o_rdata;
  wire  [3:0] o_t2_pin_oe;
  wire  [3:0] o_t2_pin_out;
  wire        o_t2_overflow, o_t2l_overflow;
  wire        o_t2_count_in, o_t2_external_trigger_pin_in, o_t0_reload, o_t1_reload;
  wire        o_t0_run, o_t1_run, o_t2_run, o_t2l_run, o_t2_split;
  int         n_fail, n_compared;
  tsrc_top tsrc_top_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_sfr_page(i_sfr_page), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_t2_tick(i_t2_tick), .i_t2l_tick(i_t2l_tick),
    .i_t0_mode2(i_t0_mode2), .i_t1_mode2(i_t1_mode2),
    .i_t2_pin_in(i_t2_pin_in), .i_t2_external_trigger_pin_pin_in(i_t2_external_trigger_pin_pin_in),
    .o_t2_pin_out(o_t2_pin_out), .o_t2_pin_oe(o_t2_pin_oe),
    .o_t2_count_in(o_t2_count_in), .o_t2_external_trigger_pin_in(o_t2_external_trigger_pin_in),
    .o_t0_run(o_t0_run), .o_t1_run(o_t1_run), .o_t2_run(o_t2_run),
    .o_t2l_run(o_t2l_run), .o_t0_reload(o_t0_reload),
    .o_t1_reload(o_t1_reload), .o_t2_overflow(o_t2_overflow),
    .o_t2l_overflow(o_t2l_overflow),
    .o_t2_split(o_t2_split));
  // free-running core clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write; returns just after the edge that takes it
  task automatic wr_reg(input logic [7:0] a, input logic [3:0] p,
                        input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_sfr_page <= p;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [3:0] p,
                        input logic [7:0] exp);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    i_sfr_page <= p;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic runs_chk(input logic [3:0] exp);
    chk({4'h0, o_t2l_run, o_t2_run, o_t1_run, o_t0_run}, {4'h0, exp});
  endtask
  task automatic t_reset_and_regs;
    for (int a = 8'hca; a <= 8'hcd; a++) begin
      rd_chk(a[7:0], 4'h0, 8'h00);
      wr_reg(a[7:0], 4'h5, a[7:0] ^ 8'h5a);
      rd_chk(a[7:0], 4'h0, a[7:0] ^ 8'h5a);
    end
    for (int p = 1; p <= 3; p++) begin
      rd_chk(8'h95, p[3:0], 8'h00);
    end
    runs_chk(4'h0);
  endtask
  task automatic t_start_stop;
    wr_reg(8'h95, 4'h1, 8'h00);
    runs_chk(4'h0);
    wr_reg(8'h95, 4'h1, 8'h07);
    runs_chk(4'h7);
    wr_reg(8'h95, 4'h1, 8'h20);
    runs_chk(4'h7);
    wr_reg(8'h95, 4'h3, 8'h00);
    runs_chk(4'h7);
    wr_reg(8'h95, 4'h3, 8'h01);
    runs_chk(4'h6);
    wr_reg(8'h95, 4'h3, 8'h02);
    runs_chk(4'h4);
    wr_reg(8'h95, 4'h3, 8'h04);
    runs_chk(4'h0);
  endtask
  task automatic t_split;
    wr_reg(8'h9b, 4'h0, 8'h80);
    chk({7'h00, o_t2_split}, 8'h01);
    wr_reg(8'h95, 4'h1, 8'h24);
    runs_chk(4'hc);
    wr_reg(8'h95, 4'h3, 8'h20);
    runs_chk(4'h4);
    wr_reg(8'h95, 4'h3, 8'h04);
    runs_chk(4'h0);
  endtask
  task automatic t_reload;
    @(posedge i_core_clk);
    i_t0_mode2 <= 1'b1;
    wr_reg(8'h95, 4'h2, 8'h01);
    chk({6'h00, o_t1_reload, o_t0_reload}, 8'h01);
    wr_reg(8'h95, 4'h2, 8'h02);
    chk({6'h00, o_t1_reload, o_t0_reload}, 8'h00);
    @(posedge i_core_clk);
    i_t1_mode2 <= 1'b1;
    wr_reg(8'h95, 4'h2, 8'h02);
    chk({6'h00, o_t1_reload, o_t0_reload}, 8'h02);
    wr_reg(8'h9b, 4'h0, 8'h00);
    wr_reg(8'hca, 4'h0, 8'h12);
    wr_reg(8'hcb, 4'h0, 8'h34);
    wr_reg(8'h95, 4'h2, 8'h04);
    rd_chk(8'hcc, 4'h0, 8'h12);
    rd_chk(8'hcd, 4'h0, 8'h34);
    wr_reg(8'h9b, 4'h0, 8'h80);
    wr_reg(8'hcc, 4'h0, 8'h56);
    wr_reg(8'hcd, 4'h0, 8'h78);
    wr_reg(8'h95, 4'h2, 8'h04);
    rd_chk(8'hcc, 4'h0, 8'h56);
    rd_chk(8'hcd, 4'h0, 8'h34);
    wr_reg(8'h95, 4'h2, 8'h20);
    rd_chk(8'hcc, 4'h0, 8'h12);
  endtask
  task automatic t_pins;
    wr_reg(8'h9b, 4'h0, 8'h04);
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'ha4, 4'h1, {s[1:0], 6'h00});
      rd_chk(8'ha4, 4'h1, {s[1:0], 6'h00});
      chk({4'h0, o_t2_pin_oe}, 8'h01 << s);
      @(posedge i_core_clk);
      i_t2_pin_in <= 4'h1 << s;
      i_t2_external_trigger_pin_pin_in <= ~(4'h1 << s);
      @(posedge i_core_clk);
      #1;
      chk({6'h00, o_t2_count_in, o_t2_external_trigger_pin_in}, 8'h02);
    end
  endtask
  // full mode carries into the high byte and reloads both; split mode
  // keeps the halves apart; clock-out pins toggle on high overflow
  task automatic t_count;
    wr_reg(8'hcc, 4'h0, 8'hff);
    wr_reg(8'hcd, 4'h0, 8'hff);
    wr_reg(8'h95, 4'h1, 8'h04);
    @(posedge i_core_clk);
    i_t2_tick <= 1'b1;
    @(posedge i_core_clk);
    i_t2_tick <= 1'b0;
    #1;
    chk({o_t2_pin_out, 2'b00, o_t2l_overflow, o_t2_overflow},
        8'hf1);
    rd_chk(8'hcc, 4'h0, 8'h12);
    rd_chk(8'hcd, 4'h0, 8'h34);
    wr_reg(8'h9b, 4'h0, 8'h80);
    wr_reg(8'hcc, 4'h0, 8'hff);
    wr_reg(8'hcd, 4'h0, 8'h00);
    wr_reg(8'h95, 4'h1, 8'h20);
    @(posedge i_core_clk);
    i_t2l_tick <= 1'b1;
    @(posedge i_core_clk);
    i_t2l_tick <= 1'b0;
    #1;
    chk({o_t2_pin_out, 2'b00, o_t2l_overflow, o_t2_overflow},
        8'hf2);
    rd_chk(8'hcc, 4'h0, 8'h12);
    rd_chk(8'hcd, 4'h0, 8'h00);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d, comparisons %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // reset for five cycles, then the scenarios in turn
  initial begin
    {i_rst_b, i_wr, i_rd, i_t0_mode2, i_t1_mode2} = 5'h00;
    {i_addr, i_wdata, i_sfr_page} = 20'h0_0000;
    {i_t2_pin_in, i_t2_external_trigger_pin_pin_in} = 8'h00;
    {i_t2_tick, i_t2l_tick} = 2'b00;
    repeat (5) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    t_reset_and_regs();
    t_start_stop();
    t_split();
    t_reload();
    t_pins();
    t_count();
    print_verdict();
  end
  // the scenarios need well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
endmodule // test_tsrc_top
bind tsrc_top tsrc_checker tsrc_checker_i (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_sfr_page(i_sfr_page), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_t0_mode2(i_t0_mode2), .o_t2_pin_oe(o_t2_pin_oe),
  .o_t0_run(o_t0_run), .o_t1_run(o_t1_run), .o_t2_run(o_t2_run),
  .o_t2l_run(o_t2l_run), .o_t0_reload(o_t0_reload),
  .o_t2_split(o_t2_split));
`default_nettype wire

// File: sim/tsrc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tsrc_checker (
  input wire logic       i_core_clk,
  input wire logic       i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [3:0] i_sfr_page,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_t0_mode2,
  input wire logic [3:0] o_t2_pin_oe,
  input wire logic       o_t0_run,
  input wire logic       o_t1_run,
  input wire logic       o_t2_run,
  input wire logic       o_t2l_run,
  input wire logic       o_t0_reload,
  input wire logic       o_t2_split
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // command writes decoded per page at the shared offset
  logic st, rl, sp;
  assign st = i_wr && i_addr == 8'h95 && i_sfr_page == 4'h1;
  assign rl = i_wr && i_addr == 8'h95 && i_sfr_page == 4'h2;
  assign sp = i_wr && i_addr == 8'h95 && i_sfr_page == 4'h3;
  a_start_t0: assert property (st && i_wdata[0] |=> o_t0_run)
    else $error("timer 0 not started");
  a_start_t1: assert property (st && i_wdata[1] |=> o_t1_run)
    else $error("timer 1 not started");
  a_start_t2: assert property (st && i_wdata[2] |=> o_t2_run)
    else $error("timer 2 not started");
  a_start_low_half: assert property (st && i_wdata[5] && o_t2_split
    |=> o_t2l_run) else $error("low half not started");
  a_start_together: assert property (st && i_wdata[2:0] == 3'b111
    |=> o_t0_run && o_t1_run && o_t2_run) else $error("start not joint");
  a_zero_no_action: assert property (st && i_wdata == 8'h00
    |=> $stable({o_t0_run, o_t1_run, o_t2_run, o_t2l_run}))
    else $error("zero command changed run state");
  a_stop_t0: assert property (sp && i_wdata[0] |=> !o_t0_run)
    else $error("timer 0 not stopped");
  a_stop_t1: assert property (sp && i_wdata[1] |=> !o_t1_run)
    else $error("timer 1 not stopped");
  a_stop_t2: assert property (sp && i_wdata[2] |=> !o_t2_run)
    else $error("timer 2 not stopped");
  a_stop_low_half: assert property (sp && i_wdata[5] && o_t2_split
    |=> !o_t2l_run) else $error("low half not stopped");
  a_reload_t0: assert property (rl && i_wdata[0] && i_t0_mode2
    |=> o_t0_reload) else $error("timer 0 reload missing");
  a_cmd_read_zero: assert property (i_rd && i_addr == 8'h95
    |=> o_rdata == 8'h00) else $error("command register read not zero");
  a_pin_oe_single: assert property ($onehot0(o_t2_pin_oe))
    else $error("more than one pin pair enabled");
  // main scenarios reached
  c_start: cover property (st && i_wdata[2:0] == 3'b111);
  c_low_stop: cover property (sp && i_wdata[5] && o_t2_split);
  c_reload: cover property (rl && i_wdata[0] && i_t0_mode2);
endmodule // tsrc_checker
`default_nettype wire
